// ==== src/gmc_pkg.sv ====
// Package of command decode constants for the gauge command block
package gmc_pkg;
   localparam int WORD_W = 16;
   localparam int DATA_W = 13;
   localparam logic [2:0] SEL_CFG = 3'h0;
   localparam logic [2:0] SEL_VEL = 3'h1;
   localparam logic [2:0] SEL_POS0 = 3'h2;
   localparam logic [2:0] SEL_POS1 = 3'h3;
   localparam logic [2:0] SEL_RTZ = 3'h4;
   localparam int CFG_NULL = 12;
   localparam int CFG_FREQ = 4;
   localparam int CFG_CAL = 3;
   localparam int CFG_SLOW = 2;
   localparam int CFG_EN1 = 1;
   localparam int CFG_EN0 = 0;
   localparam int CFG_ZLOC = 7;
   localparam int VEL_APPLY1 = 9;
   localparam int VEL_APPLY0 = 8;
   localparam logic [12:0] VEL_ZERO_MASK = 13'h1c00;
   localparam logic [7:0] VEL_TOP_DEFAULT = 8'he1;
   localparam logic [7:0] VEL_RESET = 8'he1;
   localparam int POS_DAMP = 12;
   localparam int RTZ_UNCOND = 4;
   localparam int RTZ_DIR = 2;
   localparam int RTZ_EN = 1;
   localparam int RTZ_SEL = 0;
   localparam logic [12:0] RTZ_ZERO_MASK = 13'h1fe8;
   localparam int CAL_REF_NS = 8000;
   localparam int LINK_PERIOD_NS = 48;
endpackage

// ==== src/gmc_spi_rx.sv ====
// SPI receiver on the link clock, hands whole words across by toggle
`timescale 1ns/1ns
module gmc_spi_rx
   import gmc_pkg::*;
(
   input  wire logic              sclk,
   input  wire logic              cs_n,
   input  wire logic              si,
   input  wire logic              mclk,
   input  wire logic              rst_n,
   output logic [WORD_W-1:0]      word,
   output logic                   word_valid
);
   logic [WORD_W-1:0] shift;
   logic [4:0]        count;
   logic [WORD_W-1:0] held;
   logic              tog;
   logic [2:0]        tog_sync;

   // Frame restarts the counter through async cs; no edge needed after cs
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         count <= 5'h0;
      end else begin
         count <= (count == 5'h10) ? count : count + 5'h1;
      end
   end

   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         shift <= '0;
      end else if (!cs_n) begin
         shift <= {shift[WORD_W-2:0], si};
      end
   end

   // Sixteenth bit completes the word; held stays stable through crossing
   always_ff @(posedge sclk or negedge rst_n) begin
      if (!rst_n) begin
         held <= '0;
         tog <= 1'b0;
      end else if (!cs_n && count == 5'hf) begin
         held <= {shift[WORD_W-2:0], si};
         tog <= ~tog;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tog_sync <= 3'h0;
      end else begin
         tog_sync <= {tog_sync[1:0], tog};
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         word_valid <= 1'b0;
         word <= '0;
      end else begin
         word_valid <= tog_sync[2] ^ tog_sync[1];
         if (tog_sync[2] ^ tog_sync[1]) begin
            word <= held;
         end
      end
   end
endmodule

// ==== src/gmc_top.sv ====
// Command word decoder and setting store for two step-motor gauges
`timescale 1ns/1ns
module gmc_top
   import gmc_pkg::*;
#(
   parameter logic [7:0] VEL_TOP = VEL_TOP_DEFAULT
)(
   input  wire logic        MCLK,
   input  wire logic        RST_N,
   input  wire logic        SCLK,
   input  wire logic        CS_N,
   input  wire logic        SI,
   input  wire logic        GAUGE0_STALL,
   input  wire logic        GAUGE1_STALL,
   input  wire logic [7:0]  GAUGE0_SPEED,
   input  wire logic [7:0]  GAUGE1_SPEED,
   output logic             SO,
   output logic             SO_OE,
   output logic             CALIB_FREQ_SELECT,
   output logic             CALIB_START,
   output logic             OSC_SLOWDOWN,
   output logic             GAUGE0_DRIVER_ENABLE,
   output logic             GAUGE1_DRIVER_ENABLE,
   output logic [7:0]       GAUGE0_MAX_VELOCITY,
   output logic [7:0]       GAUGE1_MAX_VELOCITY,
   output logic             GAUGE0_RAMP_DOWN,
   output logic             GAUGE1_RAMP_DOWN,
   output logic [11:0]      GAUGE0_TARGET,
   output logic [11:0]      GAUGE1_TARGET,
   output logic             GAUGE0_DAMPING_DISABLE,
   output logic             GAUGE1_DAMPING_DISABLE,
   output logic             GAUGE0_ZEROING,
   output logic             GAUGE1_ZEROING,
   output logic             ZEROING_FULL_STEP,
   output logic             ZEROING_DIRECTION,
   output logic             UNCONDITIONAL_ZEROING
);
   import gmc_pkg::*;

   // Index range of the step table bounds the parameter
   if (VEL_TOP == 8'h0 || VEL_TOP > VEL_TOP_DEFAULT) begin : g_bad_top
      $error("VEL_TOP out of range");
   end

   logic [WORD_W-1:0] word;
   logic              word_valid;
   logic [2:0]        sel;
   logic [12:0]       data;
   logic              vel_ok;
   logic              rtz_ok;
   logic [7:0]        next_vel;
   logic [1:0]        stall_s0;
   logic [1:0]        stall_s1;
   // Reset limit never above a smaller table top
   localparam logic [7:0] VEL_INIT = (VEL_RESET > VEL_TOP) ? VEL_TOP : VEL_RESET;

   gmc_spi_rx u_rx (
      .sclk       (SCLK),
      .cs_n       (CS_N),
      .si         (SI),
      .mclk       (MCLK),
      .rst_n      (RST_N),
      .word       (word),
      .word_valid (word_valid)
   );

   assign sel = word[WORD_W-1:DATA_W];
   assign data = word[DATA_W-1:0];
   assign vel_ok = (data & VEL_ZERO_MASK) == 13'h0;
   assign rtz_ok = (data & RTZ_ZERO_MASK) == 13'h0;
   // Zero index treated as slowest entry; large ones clamp to the top
   always_comb begin
      next_vel = data[7:0];
      if (data[7:0] > VEL_TOP) begin
         next_vel = VEL_TOP;
      end else if (data[7:0] == 8'h0) begin
         next_vel = 8'h1;
      end
   end

   // Nothing readable comes back; serial output never driven
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         SO <= 1'b0;
         SO_OE <= 1'b0;
      end else begin
         SO <= 1'b0;
         SO_OE <= 1'b0;
      end
   end

   // Stall inputs come from the analog front end
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         stall_s0 <= 2'h0;
         stall_s1 <= 2'h0;
      end else begin
         stall_s0 <= {stall_s0[0], GAUGE0_STALL};
         stall_s1 <= {stall_s1[0], GAUGE1_STALL};
      end
   end

   // Configuration word; null command leaves everything alone
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         CALIB_FREQ_SELECT <= 1'b0;
         OSC_SLOWDOWN <= 1'b0;
         GAUGE0_DRIVER_ENABLE <= 1'b0;
         GAUGE1_DRIVER_ENABLE <= 1'b0;
      end else if (word_valid && sel == SEL_CFG && !data[CFG_NULL]) begin
         CALIB_FREQ_SELECT <= data[CFG_FREQ];
         OSC_SLOWDOWN <= data[CFG_SLOW];
         GAUGE1_DRIVER_ENABLE <= data[CFG_EN1];
         GAUGE0_DRIVER_ENABLE <= data[CFG_EN0];
      end
   end

   // Calibration request is a one-cycle pulse to the clock trimmer
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         CALIB_START <= 1'b0;
      end else begin
         CALIB_START <= word_valid && sel == SEL_CFG && !data[CFG_NULL]
                        && data[CFG_CAL];
      end
   end

   // Maximum velocity per gauge
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         GAUGE0_MAX_VELOCITY <= VEL_INIT;
         GAUGE1_MAX_VELOCITY <= VEL_INIT;
      end else if (word_valid && sel == SEL_VEL && vel_ok) begin
         if (data[VEL_APPLY0]) begin
            GAUGE0_MAX_VELOCITY <= next_vel;
         end
         if (data[VEL_APPLY1]) begin
            GAUGE1_MAX_VELOCITY <= next_vel;
         end
      end
   end

   // Ramp-down asks the motion engine to decelerate while over the limit
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         GAUGE0_RAMP_DOWN <= 1'b0;
         GAUGE1_RAMP_DOWN <= 1'b0;
      end else begin
         GAUGE0_RAMP_DOWN <= GAUGE0_SPEED > GAUGE0_MAX_VELOCITY;
         GAUGE1_RAMP_DOWN <= GAUGE1_SPEED > GAUGE1_MAX_VELOCITY;
      end
   end

   // Target positions with damping control
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         GAUGE0_TARGET <= 12'h0;
         GAUGE1_TARGET <= 12'h0;
         GAUGE0_DAMPING_DISABLE <= 1'b0;
         GAUGE1_DAMPING_DISABLE <= 1'b0;
      end else if (word_valid && sel == SEL_POS0) begin
         GAUGE0_TARGET <= data[11:0];
         GAUGE0_DAMPING_DISABLE <= data[POS_DAMP];
      end else if (word_valid && sel == SEL_POS1) begin
         GAUGE1_TARGET <= data[11:0];
         GAUGE1_DAMPING_DISABLE <= data[POS_DAMP];
      end
   end

   // Return to zero; auto mode stops on a synchronised stall
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         GAUGE0_ZEROING <= 1'b0;
         GAUGE1_ZEROING <= 1'b0;
         ZEROING_DIRECTION <= 1'b0;
         UNCONDITIONAL_ZEROING <= 1'b0;
      end else if (word_valid && sel == SEL_RTZ && rtz_ok) begin
         ZEROING_DIRECTION <= data[RTZ_DIR];
         UNCONDITIONAL_ZEROING <= data[RTZ_UNCOND];
         if (data[RTZ_SEL]) begin
            GAUGE1_ZEROING <= data[RTZ_EN];
         end else begin
            GAUGE0_ZEROING <= data[RTZ_EN];
         end
      end else if (!UNCONDITIONAL_ZEROING) begin
         if (stall_s0[1]) begin
            GAUGE0_ZEROING <= 1'b0;
         end
         if (stall_s1[1]) begin
            GAUGE1_ZEROING <= 1'b0;
         end
      end
   end

   // Full-step single-coil drive while any gauge zeroes
   always_ff @(posedge MCLK or negedge RST_N) begin
      if (!RST_N) begin
         ZEROING_FULL_STEP <= 1'b0;
      end else begin
         ZEROING_FULL_STEP <= GAUGE0_ZEROING | GAUGE1_ZEROING;
      end
   end

   property p_cfg_en;
      @(posedge MCLK) disable iff (!RST_N)
      word_valid && sel == SEL_CFG && !data[CFG_NULL]
      |=> GAUGE0_DRIVER_ENABLE == $past(data[CFG_EN0])
          && GAUGE1_DRIVER_ENABLE == $past(data[CFG_EN1]);
   endproperty
   a_cfg_en: assert property (p_cfg_en) else $error("enable not taken");

   property p_cal;
      @(posedge MCLK) disable iff (!RST_N)
      CALIB_START |-> $past(word_valid) && $past(sel) == SEL_CFG;
   endproperty
   a_cal: assert property (p_cal) else $error("stray calibration");

   property p_vel_clamp;
      @(posedge MCLK) disable iff (!RST_N)
      GAUGE0_MAX_VELOCITY <= VEL_TOP && GAUGE1_MAX_VELOCITY <= VEL_TOP;
   endproperty
   a_vel_clamp: assert property (p_vel_clamp) else $error("vel high");

   property p_vel_bad;
      @(posedge MCLK) disable iff (!RST_N)
      word_valid && sel == SEL_VEL && !vel_ok |=> $stable(GAUGE0_MAX_VELOCITY);
   endproperty
   a_vel_bad: assert property (p_vel_bad) else $error("bad vel taken");

   property p_vel_skip;
      @(posedge MCLK) disable iff (!RST_N)
      word_valid && sel == SEL_VEL && !data[VEL_APPLY1]
      |=> $stable(GAUGE1_MAX_VELOCITY);
   endproperty
   a_vel_skip: assert property (p_vel_skip) else $error("vel applied");

   property p_pos;
      @(posedge MCLK) disable iff (!RST_N)
      word_valid && sel == SEL_POS0 |=> GAUGE0_TARGET == $past(data[11:0]);
   endproperty
   a_pos: assert property (p_pos) else $error("target not stored");

   property p_rtz;
      @(posedge MCLK) disable iff (!RST_N)
      word_valid && sel == SEL_RTZ && rtz_ok && data[RTZ_SEL]
      |=> GAUGE1_ZEROING == $past(data[RTZ_EN]);
   endproperty
   a_rtz: assert property (p_rtz) else $error("zeroing not set");

   property p_uncond;
      @(posedge MCLK) disable iff (!RST_N)
      UNCONDITIONAL_ZEROING && GAUGE0_ZEROING && !word_valid
      |=> GAUGE0_ZEROING;
   endproperty
   a_uncond: assert property (p_uncond) else $error("uncond stopped");

   property p_so;
      @(posedge MCLK) disable iff (!RST_N)
      !SO_OE;
   endproperty
   a_so: assert property (p_so) else $error("SO driven");

   property p_stall;
      @(posedge MCLK) disable iff (!RST_N)
      !UNCONDITIONAL_ZEROING && stall_s0[1]
      && !(word_valid && sel == SEL_RTZ && rtz_ok)
      |=> !GAUGE0_ZEROING;
   endproperty
   a_stall: assert property (p_stall) else $error("stall ignored");

   property p_rtz_bad;
      @(posedge MCLK) disable iff (!RST_N)
      word_valid && sel == SEL_RTZ && !rtz_ok
      |=> $stable(ZEROING_DIRECTION) && $stable(UNCONDITIONAL_ZEROING);
   endproperty
   a_rtz_bad: assert property (p_rtz_bad) else $error("bad rtz taken");

   property p_full;
      @(posedge MCLK) disable iff (!RST_N)
      ZEROING_FULL_STEP == $past(GAUGE0_ZEROING || GAUGE1_ZEROING);
   endproperty
   a_full: assert property (p_full) else $error("full step wrong");

   property p_ramp;
      @(posedge MCLK) disable iff (!RST_N)
      GAUGE0_SPEED > GAUGE0_MAX_VELOCITY |=> GAUGE0_RAMP_DOWN;
   endproperty
   a_ramp: assert property (p_ramp) else $error("no ramp down");

   property p_cfg_mode;
      @(posedge MCLK) disable iff (!RST_N)
      word_valid && sel == SEL_CFG && !data[CFG_NULL]
      |=> CALIB_FREQ_SELECT == $past(data[CFG_FREQ])
          && OSC_SLOWDOWN == $past(data[CFG_SLOW]);
   endproperty
   a_cfg_mode: assert property (p_cfg_mode) else $error("mode lost");

   c_vel: cover property (@(posedge MCLK) disable iff (!RST_N)
      word_valid && sel == SEL_VEL && vel_ok);
   c_rtz: cover property (@(posedge MCLK) disable iff (!RST_N)
      GAUGE0_ZEROING ##1 !GAUGE0_ZEROING);
   c_cal: cover property (@(posedge MCLK) disable iff (!RST_N)
      CALIB_START);
endmodule

// ==== test/gmc_spi_master.sv ====
// SPI master model that writes command words to the gauge block
`timescale 1ns/1ns
module gmc_spi_master (
   output logic sclk,
   output logic cs_n,
   output logic si
);
   localparam int HALF = 24;
   // Rising cs_n at start clears the receiver's bit counter
   initial begin
      sclk = 1'b0;
      cs_n = 1'b0;
      si   = 1'b0;
      #2 cs_n = 1'b1;
   end
   // Clock stands still low between frames
   task automatic send(input logic [15:0] w);
      #7 cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         si = w[i];
         #HALF sclk = 1'b1;
         #HALF sclk = 1'b0;
      end
      #HALF cs_n = 1'b1;
      // Released line must not look like a held bit
      si = ~si;
   endtask
   // Only cs_n moves, so no frame can be mistaken for a word
   task automatic cal_pulse(input int ns);
      cs_n = 1'b0;
      #ns cs_n = 1'b1;
   endtask
endmodule

// ==== test/gmc_top_tb.sv ====
// Self-checking bench for the gauge command decoder
`timescale 1ns/1ns
module gmc_top_tb;
   import gmc_pkg::*;
   localparam logic [7:0] TOP = 8'hc8;
   logic        mclk, rst_n, sclk, cs_n, si, st0, st1, so, so_oe;
   logic        cfs, cst, osl, en0, en1, rd0, rd1, dd0, dd1;
   logic        z0, z1, zfs, zdir, zunc;
   logic [7:0]  sp0, sp1, mv0, mv1;
   logic [11:0] tg0, tg1;
   int          n_errors, total_checks, n_cal;
   gmc_spi_master m (.sclk(sclk), .cs_n(cs_n), .si(si));
   gmc_top #(.VEL_TOP(TOP)) dut (
      .MCLK(mclk), .RST_N(rst_n), .SCLK(sclk), .CS_N(cs_n), .SI(si),
      .GAUGE0_STALL(st0), .GAUGE1_STALL(st1),
      .GAUGE0_SPEED(sp0), .GAUGE1_SPEED(sp1), .SO(so), .SO_OE(so_oe),
      .CALIB_FREQ_SELECT(cfs), .CALIB_START(cst), .OSC_SLOWDOWN(osl),
      .GAUGE0_DRIVER_ENABLE(en0), .GAUGE1_DRIVER_ENABLE(en1),
      .GAUGE0_MAX_VELOCITY(mv0), .GAUGE1_MAX_VELOCITY(mv1),
      .GAUGE0_RAMP_DOWN(rd0), .GAUGE1_RAMP_DOWN(rd1),
      .GAUGE0_TARGET(tg0), .GAUGE1_TARGET(tg1),
      .GAUGE0_DAMPING_DISABLE(dd0), .GAUGE1_DAMPING_DISABLE(dd1),
      .GAUGE0_ZEROING(z0), .GAUGE1_ZEROING(z1), .ZEROING_FULL_STEP(zfs),
      .ZEROING_DIRECTION(zdir), .UNCONDITIONAL_ZEROING(zunc));
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   always @(negedge mclk) if (cst === 1'b1) n_cal++;
   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Ten cycles keeps words apart and covers the sync latency
   task automatic wr(input logic [2:0] s, input logic [12:0] d);
      m.send({s, d});
      repeat (10) @(negedge mclk);
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic t_reset;
      // Reset limit is clamped to the smaller table top
      chk("max vel", {TOP, TOP}, {mv0, mv1});
      chk("so", 2'b00, {so, so_oe});
      chk("enables", 0, {en0, en1, z0, z1, zfs, cst});
      $display("reset test done");
   endtask
   task automatic t_config;
      wr(SEL_CFG, 13'h0015);
      chk("config", 4'b1101, {cfs, osl, en1, en0});
      chk("no cal", 0, n_cal[11:0]);
      wr(SEL_CFG, 13'h000a);
      m.cal_pulse(CAL_REF_NS);
      chk("cal start", 1, n_cal[11:0]);
      chk("config", 4'b0010, {cfs, osl, en1, en0});
      wr(SEL_CFG, 13'h101f);
      chk("null cfg", 4'b0010, {cfs, osl, en1, en0});
      chk("null cal", 1, n_cal[11:0]);
      $display("config test done");
   endtask
   task automatic t_velocity;
      wr(SEL_VEL, 13'h0140);
      chk("vel one", {8'h40, TOP}, {mv0, mv1});
      wr(SEL_VEL, 13'h0310);
      chk("vel both", {8'h10, 8'h10}, {mv0, mv1});
      wr(SEL_VEL, 13'h02ff);
      chk("vel clamp", {8'h10, TOP}, {mv0, mv1});
      wr(SEL_VEL, 13'h0720);
      chk("vel bad", {8'h10, TOP}, {mv0, mv1});
      sp0 = 8'h11;
      sp1 = TOP;
      repeat (3) @(negedge mclk);
      chk("ramp down", 2'b10, {rd0, rd1});
      sp0 = 8'h10;
      repeat (3) @(negedge mclk);
      chk("ramp down", 2'b00, {rd0, rd1});
      // Index zero is stored as the slowest entry
      wr(SEL_VEL, 13'h0100);
      chk("vel zero", {8'h01, TOP}, {mv0, mv1});
      $display("velocity test done");
   endtask
   task automatic t_position;
      wr(SEL_POS0, 13'h1fff);
      chk("target0", 12'hfff, tg0);
      chk("damp", 2'b10, {dd0, dd1});
      wr(SEL_POS1, 13'h0abc);
      chk("target1", 12'habc, tg1);
      wr(SEL_POS1, 13'h1000);
      chk("target1", 12'h000, tg1);
      chk("damp", 2'b11, {dd0, dd1});
      chk("target0", 12'hfff, tg0);
      $display("position test done");
   endtask
   task automatic t_zeroing;
      wr(SEL_RTZ, 13'h0017);
      chk("rtz", 4'b1011, {z1, z0, zdir, zunc});
      chk("full step", 1, zfs);
      wr(SEL_RTZ, 13'h0002);
      chk("rtz", 4'b1100, {z1, z0, zdir, zunc});
      wr(SEL_RTZ, 13'h0009);
      chk("rtz bad", 2'b11, {z1, z0});
      st0 = 1'b1;
      for (int i = 0; i < 20 && z0 !== 1'b0; i++) @(negedge mclk);
      chk("stall stop", 2'b10, {z1, z0});
      wr(SEL_RTZ, 13'h0012);
      chk("uncond hold", 4'b1101, {z1, z0, zdir, zunc});
      st0 = 1'b0;
      wr(SEL_RTZ, 13'h0000);
      chk("rtz stop0", 2'b10, {z1, z0});
      wr(SEL_RTZ, 13'h0001);
      chk("rtz cancel", 3'b000, {z1, z0, zfs});
      chk("so", 2'b00, {so, so_oe});
      $display("zeroing test done");
   endtask
   initial begin
      // Falling edge after time zero so no flop misses reset
      rst_n = 1'b1;
      {st0, st1, sp0, sp1} = '0;
      #1 rst_n = 1'b0;
      repeat (4) @(negedge mclk);
      rst_n = 1'b1;
      @(negedge mclk);
      t_reset();
      t_config();
      t_velocity();
      t_position();
      t_zeroing();
      complete_run();
   end
   initial begin
      #400000;
      n_errors++;
      complete_run();
   end
endmodule
